// ### include/glop_cfg.svh
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz clk and word-indexed registers on Avalon-MM
//
// Function
// - input codes 4-7: long sleep/wake, sleep, power-on, watchdog reset
// - input codes 8,9 voltage scaling one/two; 10,11 hardware enables
// - input codes 12,13 hardware controls; 14,15 same, long debounce
// - output codes 0-3: level, 32.768kHz clock, on state, sleep state
// - output code 4 power-state change; codes 5-7 reserved, drive the inactive level
// - output 8,9 scaling done one/two; 10,11 external power enables
// - output 12-15: supply good, power good, 2MHz clock, aux reset
// - first indicator source bits 3:2: off, power, charger, manual; reset 11
// - second indicator source bits 1:0: same choices; reset 11
// - first indicator also shows non-volatile programming complete
// - second indicator also shows non-volatile programming error
// - second pin pull bits 14:13: none, down (reset), up, 11 reserved
// - edge bit 12 clear: rising if non-inverted, falling if inverted
// - edge bit 12 set: interrupt on both edges, polarity ignored
// - bit 11 second pin supply: 0 interface supply, 1 system supply
// - polarity bit 10: 0 active low, 1 active high; reset 1
`ifndef GLOP_CFG_SVH
`define GLOP_CFG_SVH

`define GLOP_PIN4_IDX    15'h781d
`define GLOP_PIN5_IDX    15'h781e
`define GLOP_STAT_IDX    15'h7820
`define GLOP_MASK_IDX    15'h7821
`define GLOP_LEVEL_IDX   15'h7822

`define GLOP_DIR         15
`define GLOP_PULL_HI     14
`define GLOP_PULL_LO     13
`define GLOP_EDGE        12
`define GLOP_DOM         11
`define GLOP_POL         10
`define GLOP_OD          9
`define GLOP_ENA         8
`define GLOP_FN_HI       7
`define GLOP_FN_LO       4
`define GLOP_SRC1_HI     3
`define GLOP_SRC1_LO     2
`define GLOP_SRC2_HI     1
`define GLOP_SRC2_LO     0

`define GLOP_PIN4_RST    16'ha40f
`define GLOP_PIN5_RST    16'ha400
`define GLOP_PIN5_MASK   16'hfc00

`define GLOP_CLK_MHZ     100
`define GLOP_SHORT_US    20
`define GLOP_LONG_US     5000
`define GLOP_SHORT_CYC   (`GLOP_SHORT_US * `GLOP_CLK_MHZ)
`define GLOP_LONG_CYC    (`GLOP_LONG_US * `GLOP_CLK_MHZ)

`endif

// ### include/glop_pkg.sv
// types shared by the pin configuration block
// assumes glop_cfg.svh for numeric constants
package glop_pkg;
    typedef enum logic [1:0] {
        GLOP_SRC_OFF, GLOP_SRC_PWR, GLOP_SRC_CHG, GLOP_SRC_MAN
    } glop_src_type;
    typedef enum logic [3:0] {
        GLOP_IN_GPIO_LONG, GLOP_IN_GPIO, GLOP_IN_PWR_ONOFF,
        GLOP_IN_SLEEP_WAKE, GLOP_IN_SLEEP_WAKE_LONG, GLOP_IN_SLEEP,
        GLOP_IN_PWR_ON, GLOP_IN_WDOG, GLOP_IN_VS1, GLOP_IN_VS2,
        GLOP_IN_HWEN1, GLOP_IN_HWEN2, GLOP_IN_HWC1, GLOP_IN_HWC2,
        GLOP_IN_HWC1_LONG, GLOP_IN_HWC2_LONG
    } glop_in_fn_type;
    typedef enum logic [3:0] {
        GLOP_OUT_LEVEL, GLOP_OUT_CLK32K, GLOP_OUT_ON, GLOP_OUT_SLEEP,
        GLOP_OUT_PSC, GLOP_OUT_RSV5, GLOP_OUT_RSV6, GLOP_OUT_RSV7,
        GLOP_OUT_VS1_DONE, GLOP_OUT_VS2_DONE, GLOP_OUT_EPE1,
        GLOP_OUT_EPE2, GLOP_OUT_SYS_GOOD, GLOP_OUT_CONVERTER_POWER_GOOD,
        GLOP_OUT_CLK2M, GLOP_OUT_AUX_RST
    } glop_out_fn_type;
endpackage

// ### logic/glop_top.sv
// pin function mux, indicator drivers, second pin config, Avalon slave
// assumes pins and programming status are asynchronous to clk
`timescale 1ns/1ns
`include "glop_cfg.svh"

module glop_top #(
    parameter int LONG_CYC = `GLOP_LONG_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [16:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    output logic             irq,
    input  wire logic        pin4_in,
    output logic             pin4_out,
    output logic             pin4_oe,
    output logic             pin4_pull_up,
    output logic             pin4_pull_down,
    input  wire logic        pin5_in,
    output logic             pin5_pull_up,
    output logic             pin5_pull_down,
    output logic             pin5_supply_domain_sel,
    input  wire logic        clk32k,
    input  wire logic        clk2m,
    input  wire logic        on_state,
    input  wire logic        sleep_state,
    input  wire logic        power_state_change,
    input  wire logic        vs1_done,
    input  wire logic        vs2_done,
    input  wire logic        ext_power_enable1,
    input  wire logic        ext_power_enable2,
    input  wire logic        system_supply_good,
    input  wire logic        converter_power_good,
    input  wire logic        aux_reset,
    input  wire logic        power_state_status,
    input  wire logic        charger_status,
    input  wire logic        nv_prog_done,
    input  wire logic        nv_prog_error,
    output logic             gpio_in_level,
    output logic             power_onoff_req,
    output logic             sleep_wake_req,
    output logic             sleep_req,
    output logic             power_on_req,
    output logic             watchdog_reset,
    output logic             voltage_scaling_one,
    output logic             voltage_scaling_two,
    output logic             hw_enable1,
    output logic             hw_enable2,
    output logic             hw_control1,
    output logic             hw_control2,
    output logic             first_indicator,
    output logic             second_indicator
);

    localparam int SHORT_CYC = `GLOP_SHORT_CYC;

    // active-level view of a pin under its polarity bit
    function automatic logic apply_pol(input logic lvl, input logic pol);
        return lvl ^ ~pol;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0] pin4_nv_control;
    logic [15:0] pin5_nv_control;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic [2:0]  out_level;
    logic        ack;
    logic [14:0] idx;
    logic        wr_go;
    logic [2:0]  events;

    assign idx = address[16:2];
    assign wr_go = write & ack;

    // one wait cycle per access; keeps read data from a flop
    assign waitrequest = (read | write) & ~ack;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (read | write) & ~ack;
        end
    end

    // read data captured as the answer cycle opens
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readdata <= 32'h0;
        end else if (read & ~ack) begin
            unique case (idx)
                `GLOP_PIN4_IDX:  readdata <= {16'h0, pin4_nv_control};
                `GLOP_PIN5_IDX:  readdata <= {16'h0, pin5_nv_control};
                `GLOP_STAT_IDX:  readdata <= {29'h0, irq_status};
                `GLOP_MASK_IDX:  readdata <= {29'h0, irq_mask};
                `GLOP_LEVEL_IDX: readdata <= {29'h0, out_level};
                default:         readdata <= 32'h0;
            endcase
        end
    end

    // configuration registers; unmapped writes are dropped
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin4_nv_control <= `GLOP_PIN4_RST;
            pin5_nv_control <= `GLOP_PIN5_RST;
            irq_mask <= 3'h0;
            out_level <= 3'h0;
        end else if (wr_go) begin
            if (idx == `GLOP_PIN4_IDX) begin
                pin4_nv_control <= writedata[15:0];
            end
            if (idx == `GLOP_PIN5_IDX) begin
                pin5_nv_control <= writedata[15:0] & `GLOP_PIN5_MASK;
            end
            if (idx == `GLOP_MASK_IDX) begin
                irq_mask <= writedata[2:0];
            end
            if (idx == `GLOP_LEVEL_IDX) begin
                out_level <= writedata[2:0];
            end
        end
    end

    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= 3'h0;
        end else if (wr_go && idx == `GLOP_STAT_IDX) begin
            irq_status <= (irq_status & ~writedata[2:0]) | events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////
    // synchronisers
    logic [1:0] s4, s5, sdone, serr;
    logic       pin5_q;
    logic       done_q;
    logic       err_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s4 <= 2'h0;
            s5 <= 2'h0;
            sdone <= 2'h0;
            serr <= 2'h0;
        end else begin
            s4 <= {s4[0], pin4_in};
            s5 <= {s5[0], pin5_in};
            sdone <= {sdone[0], nv_prog_done};
            serr <= {serr[0], nv_prog_error};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // debounce: short and long filters on the first pin
    logic [19:0] short_cnt;
    logic [19:0] long_cnt;
    logic        short_lvl;
    logic        long_lvl;
    logic        raw4;

    assign raw4 = apply_pol(s4[1], pin4_nv_control[`GLOP_POL]);

    // a change must stand for the whole interval before it is taken
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            short_cnt <= 20'h0;
            short_lvl <= 1'b0;
        end else if (raw4 == short_lvl) begin
            short_cnt <= 20'h0;
        end else if (short_cnt == 20'(SHORT_CYC - 1)) begin
            short_lvl <= raw4;
            short_cnt <= 20'h0;
        end else begin
            short_cnt <= short_cnt + 20'h1;
        end
    end

    // long interval filter, count is a parameter for short runs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            long_cnt <= 20'h0;
            long_lvl <= 1'b0;
        end else if (raw4 == long_lvl) begin
            long_cnt <= 20'h0;
        end else if (long_cnt == 20'(LONG_CYC - 1)) begin
            long_lvl <= raw4;
            long_cnt <= 20'h0;
        end else begin
            long_cnt <= long_cnt + 20'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // first pin input functions
    glop_pkg::glop_in_fn_type in_fn;
    logic in_mode;
    logic [11:0] next_req;

    assign in_fn = glop_pkg::glop_in_fn_type'(pin4_nv_control[7:4]);
    assign in_mode = pin4_nv_control[`GLOP_DIR] & pin4_nv_control[`GLOP_ENA];

    // request decode; only the selected function sees the pin
    always_comb begin
        next_req = 12'h0;
        if (in_mode) begin
            unique case (in_fn)
                glop_pkg::GLOP_IN_GPIO_LONG:       next_req[0] = long_lvl;
                glop_pkg::GLOP_IN_GPIO:            next_req[0] = short_lvl;
                glop_pkg::GLOP_IN_PWR_ONOFF:       next_req[1] = short_lvl;
                glop_pkg::GLOP_IN_SLEEP_WAKE:      next_req[2] = short_lvl;
                glop_pkg::GLOP_IN_SLEEP_WAKE_LONG: next_req[2] = long_lvl;
                glop_pkg::GLOP_IN_SLEEP:           next_req[3] = short_lvl;
                glop_pkg::GLOP_IN_PWR_ON:          next_req[4] = short_lvl;
                glop_pkg::GLOP_IN_WDOG:            next_req[5] = short_lvl;
                glop_pkg::GLOP_IN_VS1:             next_req[6] = short_lvl;
                glop_pkg::GLOP_IN_VS2:             next_req[7] = short_lvl;
                glop_pkg::GLOP_IN_HWEN1:           next_req[8] = short_lvl;
                glop_pkg::GLOP_IN_HWEN2:           next_req[9] = short_lvl;
                glop_pkg::GLOP_IN_HWC1:            next_req[10] = short_lvl;
                glop_pkg::GLOP_IN_HWC2:            next_req[11] = short_lvl;
                glop_pkg::GLOP_IN_HWC1_LONG:       next_req[10] = long_lvl;
                glop_pkg::GLOP_IN_HWC2_LONG:       next_req[11] = long_lvl;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {hw_control2, hw_control1, hw_enable2, hw_enable1,
             voltage_scaling_two, voltage_scaling_one, watchdog_reset,
             power_on_req, sleep_req, sleep_wake_req, power_onoff_req,
             gpio_in_level} <= 12'h0;
        end else begin
            {hw_control2, hw_control1, hw_enable2, hw_enable1,
             voltage_scaling_two, voltage_scaling_one, watchdog_reset,
             power_on_req, sleep_req, sleep_wake_req, power_onoff_req,
             gpio_in_level} <= next_req[11:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // first pin output functions; clocks pass unsynchronised by nature
    glop_pkg::glop_out_fn_type out_fn;
    logic next_out;

    assign out_fn = glop_pkg::glop_out_fn_type'(pin4_nv_control[7:4]);

    always_comb begin
        next_out = 1'b0;
        unique case (out_fn)
            glop_pkg::GLOP_OUT_LEVEL:    next_out = out_level[0];
            glop_pkg::GLOP_OUT_CLK32K:   next_out = clk32k;
            glop_pkg::GLOP_OUT_ON:       next_out = on_state;
            glop_pkg::GLOP_OUT_SLEEP:    next_out = sleep_state;
            glop_pkg::GLOP_OUT_PSC:      next_out = power_state_change;
            glop_pkg::GLOP_OUT_RSV5,
            glop_pkg::GLOP_OUT_RSV6,
            glop_pkg::GLOP_OUT_RSV7:     next_out = 1'b0;
            glop_pkg::GLOP_OUT_VS1_DONE: next_out = vs1_done;
            glop_pkg::GLOP_OUT_VS2_DONE: next_out = vs2_done;
            glop_pkg::GLOP_OUT_EPE1:     next_out = ext_power_enable1;
            glop_pkg::GLOP_OUT_EPE2:     next_out = ext_power_enable2;
            glop_pkg::GLOP_OUT_SYS_GOOD: next_out = system_supply_good;
            glop_pkg::GLOP_OUT_CONVERTER_POWER_GOOD: next_out = converter_power_good;
            glop_pkg::GLOP_OUT_CLK2M:    next_out = clk2m;
            glop_pkg::GLOP_OUT_AUX_RST:  next_out = aux_reset;
        endcase
    end

    // open drain drives only the low level
    logic drive_lvl;
    assign drive_lvl = apply_pol(next_out, pin4_nv_control[`GLOP_POL]);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin4_out <= 1'b0;
            pin4_oe <= 1'b0;
        end else begin
            pin4_out <= drive_lvl;
            pin4_oe <= ~pin4_nv_control[`GLOP_DIR]
                     & pin4_nv_control[`GLOP_ENA]
                     & ~(pin4_nv_control[`GLOP_OD] & drive_lvl);
        end
    end

    assign pin4_pull_down = ~pin4_nv_control[14] & pin4_nv_control[13];
    assign pin4_pull_up = pin4_nv_control[14] & ~pin4_nv_control[13];

    ////////////////////////////////////////////////////////////////////
    // indicators; programming status overrides any source
    glop_pkg::glop_src_type src1, src2;
    logic sel1, sel2;

    assign src1 = glop_pkg::glop_src_type'(pin4_nv_control[3:2]);
    assign src2 = glop_pkg::glop_src_type'(pin4_nv_control[1:0]);

    always_comb begin
        sel1 = 1'b0;
        sel2 = 1'b0;
        unique case (src1)
            glop_pkg::GLOP_SRC_OFF: sel1 = 1'b0;
            glop_pkg::GLOP_SRC_PWR: sel1 = power_state_status;
            glop_pkg::GLOP_SRC_CHG: sel1 = charger_status;
            glop_pkg::GLOP_SRC_MAN: sel1 = out_level[1];
        endcase
        unique case (src2)
            glop_pkg::GLOP_SRC_OFF: sel2 = 1'b0;
            glop_pkg::GLOP_SRC_PWR: sel2 = power_state_status;
            glop_pkg::GLOP_SRC_CHG: sel2 = charger_status;
            glop_pkg::GLOP_SRC_MAN: sel2 = out_level[2];
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            first_indicator <= 1'b0;
            second_indicator <= 1'b0;
        end else begin
            first_indicator <= sel1 | sdone[1];
            second_indicator <= sel2 | serr[1];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // second pin: pull, supply domain, edge interrupt
    logic act5, act5_q, rise5, fall5;

    assign pin5_pull_down = ~pin5_nv_control[14] & pin5_nv_control[13];
    assign pin5_pull_up = pin5_nv_control[14] & ~pin5_nv_control[13];
    assign pin5_supply_domain_sel = pin5_nv_control[`GLOP_DOM];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin5_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            pin5_q <= s5[1];
            done_q <= sdone[1];
            err_q <= serr[1];
        end
    end

    assign rise5 = s5[1] & ~pin5_q;
    assign fall5 = ~s5[1] & pin5_q;
    assign act5 = pin5_nv_control[`GLOP_POL] ? rise5 : fall5;
    assign act5_q = rise5 | fall5;
    assign events[0] = pin5_nv_control[`GLOP_EDGE] ? act5_q : act5;
    assign events[1] = sdone[1] & ~done_q;
    assign events[2] = serr[1] & ~err_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_req;
        (read | write) && waitrequest;
    endsequence
    sequence s_done;
        !waitrequest;
    endsequence

    property p_wait_one;
        s_req |=> s_done;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("access not answered after one wait cycle");

    property p_rise_irq;
        !pin5_nv_control[12] && pin5_nv_control[10] && rise5
            |=> irq_status[0];
    endproperty
    a_rise_irq: assert property (p_rise_irq)
        else $error("rising edge did not set pin event");

    property p_fall_quiet;
        !pin5_nv_control[12] && pin5_nv_control[10] && fall5
            && !rise5 && !irq_status[0] |=> !irq_status[0];
    endproperty
    a_fall_quiet: assert property (p_fall_quiet)
        else $error("falling edge set event in rising mode");

    property p_both;
        pin5_nv_control[12] && fall5 |=> irq_status[0];
    endproperty
    a_both: assert property (p_both)
        else $error("edge missed in both-edge mode");

    property p_ind1;
        sdone[1] |=> first_indicator;
    endproperty
    a_ind1: assert property (p_ind1)
        else $error("first indicator missing program done");

    property p_ind2;
        serr[1] |=> second_indicator;
    endproperty
    a_ind2: assert property (p_ind2)
        else $error("second indicator missing program error");

    property p_rsv;
        out_fn inside {glop_pkg::GLOP_OUT_RSV5, glop_pkg::GLOP_OUT_RSV6,
            glop_pkg::GLOP_OUT_RSV7}
            |=> pin4_out == ~$past(pin4_nv_control[`GLOP_POL]);
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved output code drove a function");

    property p_pull;
        pin5_nv_control[14:13] == 2'h1 |-> pin5_pull_down && !pin5_pull_up;
    endproperty
    a_pull: assert property (p_pull)
        else $error("pull-down code not honoured");

    property p_sleep_in;
        in_mode && in_fn == glop_pkg::GLOP_IN_SLEEP
            |=> sleep_req == $past(short_lvl);
    endproperty
    a_sleep_in: assert property (p_sleep_in)
        else $error("sleep request does not follow pin");

    property p_long;
        $rose(long_lvl) |-> $past(raw4, 1) && short_lvl;
    endproperty
    a_long: assert property (p_long)
        else $error("long filter settled before short filter");
endmodule

// ### sim/glop_board.sv
// board model for one pin: a switch, pull resistors and the device drive
// assumes the bench moves the switch just after a rising clk edge
`timescale 1ns/1ns

module glop_board (
    input  wire logic clk,
    input  wire logic sw_on,
    input  wire logic sw_level,
    input  wire logic pin_oe,
    input  wire logic pin_out,
    input  wire logic pull_up,
    input  wire logic pull_down,
    output logic      pin
);
    logic float_q = 1'b0;
    // a floating pin wanders, so a stale level can never pass for a pull
    always_ff @(posedge clk) begin
        float_q <= ~float_q;
    end
    // device drive first, then the switch, then the pull resistors
    always_comb begin
        if (pin_oe) pin = pin_out;
        else if (sw_on) pin = sw_level;
        else if (pull_up) pin = 1'b1;
        else if (pull_down) pin = 1'b0;
        else pin = float_q;
    end
endmodule

// ### sim/gpio_led_otp_pin_config_bench.sv
// self-checking bench for the pin configuration block
// assumes glop_top with a shortened long debounce and the board model
`timescale 1ns/1ns
`include "glop_cfg.svh"

module gpio_led_otp_pin_config_bench;
    localparam int LC = 2500;
    logic clk, reset_n, read, write, waitrequest, irq;
    logic [16:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [15:0] s, req, cfg;
    logic [4:0] v;
    logic pin4_in, pin4_out, pin4_oe, pin4_pull_up, pin4_pull_down, sw4;
    logic pin5_in, pin5_pull_up, pin5_pull_down, pin5_supply_domain_sel;
    logic sw5, clk32k, clk2m, on_state, sleep_state, power_state_change;
    logic vs1_done, vs2_done, ext_power_enable1, ext_power_enable2;
    logic system_supply_good, converter_power_good, aux_reset;
    logic power_state_status, charger_status, nv_prog_done, nv_prog_error;
    logic gpio_in_level, power_onoff_req, sleep_wake_req, sleep_req;
    logic power_on_req, watchdog_reset, voltage_scaling_one, hw_enable1;
    logic voltage_scaling_two, hw_enable2, hw_control1, hw_control2;
    logic first_indicator, second_indicator;
    int bad_count, n_compared, k;

    // output sources in function-code order, requests likewise
    assign {aux_reset, clk2m, converter_power_good, system_supply_good,
            ext_power_enable2, ext_power_enable1, vs2_done, vs1_done,
            power_state_change, sleep_state, on_state, clk32k}
        = {s[15:8], s[4:1]};
    assign req = {hw_control2, hw_control1, hw_control2, hw_control1,
                  hw_enable2, hw_enable1, voltage_scaling_two,
                  voltage_scaling_one, watchdog_reset, power_on_req,
                  sleep_req, sleep_wake_req, sleep_wake_req,
                  power_onoff_req, gpio_in_level, gpio_in_level};

    glop_top #(.LONG_CYC(LC)) uut (.*);
    glop_board b4 (.clk(clk), .sw_on(1'b1), .sw_level(sw4),
        .pin_oe(pin4_oe), .pin_out(pin4_out), .pull_up(pin4_pull_up),
        .pull_down(pin4_pull_down), .pin(pin4_in));
    glop_board b5 (.clk(clk), .sw_on(1'b1), .sw_level(sw5),
        .pin_oe(1'b0), .pin_out(1'b0), .pull_up(pin5_pull_up),
        .pull_down(pin5_pull_down), .pin(pin5_in));

    ////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    // one Avalon access; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [14:0] i,
                       input logic [15:0] d);
        int n;
        address <= {i, 2'b00};
        read <= ~w;
        write <= w;
        writedata <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) begin
            bad_count++;
            finish_test();
        end
        @(posedge clk);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // codes that share one request output share one expectation
    function automatic logic [15:0] grp(input int c);
        case (c)
            0, 1: return 16'h0003;
            3, 4: return 16'h0018;
            12, 14: return 16'h5000;
            13, 15: return 16'ha000;
            default: return 16'h0001 << c;
        endcase
    endfunction

    function automatic logic pick(input int c, input logic p, q, m);
        return c == 1 ? p : c == 2 ? q : c == 3 ? m : 1'b0;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // clock generator
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // main sequence
    initial begin
        {reset_n, read, write, address, writedata, s, sw4, sw5} = '0;
        {power_state_status, charger_status} = 2'b00;
        {nv_prog_done, nv_prog_error} = 2'b00;
        bad_count = 0;
        n_compared = 0;
        void'($urandom(94));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        chk("pin5 pull down", 1, pin5_pull_down);
        bus(0, `GLOP_PIN4_IDX, 0);
        chk("pin4 reset", 32'ha40f, rd);
        bus(0, `GLOP_PIN5_IDX, 0);
        chk("pin5 reset", 32'ha400, rd);
        bus(1, `GLOP_PIN5_IDX, 16'hffff);
        bus(0, `GLOP_PIN5_IDX, 0);
        chk("pin5 readback", 32'hfc00, rd);
        bus(0, 15'h0000, 0);
        chk("unmapped", 0, rd);
        $display("reset test done");
        // indicator sources over every code pair
        for (k = 0; k < 16; k++) begin
            v = 5'($urandom);
            power_state_status <= v[0];
            charger_status <= v[1];
            bus(1, `GLOP_LEVEL_IDX, {13'h0, v[4:2]});
            bus(1, `GLOP_PIN4_IDX, 16'ha400 | 16'(k));
            cyc(3);
            chk("first", pick(k / 4, v[0], v[1], v[3]),
                first_indicator);
            chk("second", pick(k % 4, v[0], v[1], v[4]),
                second_indicator);
        end
        // sources off, so only the programming status can light them
        bus(1, `GLOP_PIN4_IDX, 16'ha400);
        nv_prog_done <= 1'b1;
        cyc(5);
        chk("first done", 1, first_indicator);
        chk("second done", 0, second_indicator);
        nv_prog_error <= 1'b1;
        cyc(5);
        chk("second error", 1, second_indicator);
        bus(0, `GLOP_STAT_IDX, 0);
        chk("nv status", 32'h6, rd);
        {nv_prog_done, nv_prog_error} <= 2'b00;
        $display("indicator test done");
        // output function mux with random source levels
        for (k = 0; k < 16; k++) begin
            v = 5'($urandom);
            s <= 16'($urandom);
            bus(1, `GLOP_LEVEL_IDX, {15'h0, v[0]});
            bus(1, `GLOP_PIN4_IDX,
                16'h250f | 16'(k << 4) | {6'h0, v[1], 9'h0});
            cyc(3);
            v[2] = k == 0 ? v[0] : (k > 4 && k < 8) ? 1'b0 : s[k];
            chk("pin4 out", v[2], pin4_out);
            chk("pin4 oe", !(v[1] && v[2]), pin4_oe);
            chk("pin4 pull", 2'b01, {pin4_pull_up, pin4_pull_down});
        end
        $display("output test done");
        // input functions: long filters must lag the short one
        // the pin is made an input first, so the old drive cannot
        // leave the filters high when the switch is pressed
        for (k = 0; k < 16; k++) begin
            bus(1, `GLOP_PIN4_IDX, 16'ha50f | 16'(k << 4));
            sw4 <= 1'b0;
            cyc(LC + 100);
            sw4 <= 1'b1;
            cyc(2100);
            chk("early request",
                (k == 0 || k == 4 || k > 13) ? 16'h0 : grp(k),
                req);
            cyc(500);
            chk("late request", grp(k), req);
        end
        $display("input test done");
        // second pin edges against polarity and edge mode
        bus(1, `GLOP_MASK_IDX, 16'h0001);
        for (k = 0; k < 6; k++) begin
            cfg = {1'b1, 2'(k % 3), k[1], k[2], k[0], 10'h000};
            sw5 <= 1'b0;
            bus(1, `GLOP_PIN5_IDX, cfg);
            cyc(5);
            chk("domain", cfg[11], pin5_supply_domain_sel);
            chk("pull", {cfg[14:13] == 2'b10, cfg[14:13] == 2'b01},
                {pin5_pull_up, pin5_pull_down});
            bus(1, `GLOP_STAT_IDX, 16'h0007);
            sw5 <= 1'b1;
            cyc(6);
            chk("irq rise", cfg[12] | cfg[10], irq);
            bus(1, `GLOP_STAT_IDX, 16'h0007);
            sw5 <= 1'b0;
            cyc(6);
            bus(0, `GLOP_STAT_IDX, 0);
            chk("fall status", cfg[12] | !cfg[10],
                rd[0]);
        end
        bus(1, `GLOP_MASK_IDX, 16'h0000);
        sw5 <= 1'b1;
        cyc(6);
        chk("masked irq", 0, irq);
        $display("edge test done");
        finish_test();
    end
endmodule
